//--- src/cltf_consts.svh
/*
  Constants for the logic-test, trap and flags block of the 8-bit CPU core:
  flag positions, opcodes, lengths, cycle counts, register offsets.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef CLTF_CONSTS_SVH
`define CLTF_CONSTS_SVH

`define CLTF_FLG_C 7
`define CLTF_FLG_Z 6
`define CLTF_FLG_S 5
`define CLTF_FLG_V 4
`define CLTF_FLG_D 3
`define CLTF_FLG_H 2
`define CLTF_FLG_U1 1
`define CLTF_FLG_U2 0

`define CLTF_OP_TM_FIRST 8'h72
`define CLTF_OP_TM_LAST 8'h79
`define CLTF_OP_XOR_FIRST 8'hB2
`define CLTF_OP_XOR_LAST 8'hB9
`define CLTF_OP_TMX_FIRST 8'h78
`define CLTF_OP_EXTENDED_EXCLUSIVE_OR_FIRST 8'hB8
`define CLTF_OP_TRAP 8'hF2
`define CLTF_OP_WRK_LAST 4'h3

`define CLTF_CYC_DIR 3'h3
`define CLTF_CYC_IND 3'h4
`define CLTF_CYC_EXT 3'h3
`define CLTF_CYC_TRAP 3'h6
`define CLTF_LEN_WRK 3'h2
`define CLTF_LEN_REG 3'h3
`define CLTF_LEN_EXT 3'h4
`define CLTF_LEN_TRAP 3'h2

`define CLTF_REG_FLAGS 4'h0
`define CLTF_REG_SP 4'h4
`define CLTF_REG_STATUS 4'h8
`define CLTF_REG_CTRL 4'hC
`define CLTF_SP_RST 16'h0000
`define CLTF_STS_RST 6'h00

`define CLTF_CC_C 3'h0
`define CLTF_CC_Z 3'h1
`define CLTF_CC_S 3'h2
`define CLTF_CC_V 3'h3
`define CLTF_CC_ALW 3'h4
`define CLTF_CC_NEG 3

`endif

//--- src/cltf_pkg.sv
/*
  Types and shared decode functions of the logic-test, trap and flags block.
  Assumes the constants header is on the include path.
*/
`include "cltf_consts.svh"
package cltf_pkg;

  typedef enum logic [11:0] {
    CLTF_IDLE = 12'h001,
    CLTF_EXEC = 12'h002,
    CLTF_PCH = 12'h004,
    CLTF_PCL = 12'h008,
    CLTF_FLG = 12'h010,
    CLTF_RDH = 12'h020,
    CLTF_RDL = 12'h040,
    CLTF_CAP = 12'h080,
    CLTF_POPF = 12'h100,
    CLTF_POPH = 12'h200,
    CLTF_POPL = 12'h400,
    CLTF_POPC = 12'h800
  } cltf_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] opd;
  } cltf_ins_s;

  typedef struct packed {
    logic rd;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cltf_mem_s;

  typedef struct packed {
    cltf_state_e state;
    logic [2:0] cnt;
    logic [7:0] op;
    logic [5:0] sts;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] vec;
    logic [7:0] res;
    logic [5:0] res_sts;
    logic res_we;
    logic pc_load;
    logic [15:0] pc_new;
    cltf_mem_s mem;
    logic ack;
    logic [31:0] rdata;
    logic halt;
    logic [3:0] dwreg;
    logic [7:0] dreg;
    logic [15:0] ddisp;
  } cltf_st_s;

  function automatic logic cltf_is_tm(input logic [7:0] op);
    return (op >= `CLTF_OP_TM_FIRST) && (op <= `CLTF_OP_TM_LAST);
  endfunction

  function automatic logic cltf_is_xor(input logic [7:0] op);
    return (op >= `CLTF_OP_XOR_FIRST) && (op <= `CLTF_OP_XOR_LAST);
  endfunction

  function automatic logic cltf_is_ext(input logic [7:0] op);
    return (op[7:1] == `CLTF_OP_TMX_FIRST >> 1) || (op[7:1] == `CLTF_OP_EXTENDED_EXCLUSIVE_OR_FIRST >> 1);
  endfunction

  function automatic logic cltf_cond(input logic [7:0] f, input logic [3:0] cc);
    logic hit;
    hit = 1'b0;
    case (cc[2:0])
      `CLTF_CC_C: hit = f[`CLTF_FLG_C];
      `CLTF_CC_Z: hit = f[`CLTF_FLG_Z];
      `CLTF_CC_S: hit = f[`CLTF_FLG_S];
      `CLTF_CC_V: hit = f[`CLTF_FLG_V];
      `CLTF_CC_ALW: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit ^ cc[`CLTF_CC_NEG];
  endfunction

endpackage

//--- src/cltf_alu.sv
/*
  Combinational datapath for bit test and exclusive-or: result, flag image,
  instruction length and cycle count. Assumes operands already fetched.
*/
`timescale 1ns/100ps
`include "cltf_consts.svh"
module cltf_alu (
  input wire logic [7:0] op,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic [7:0] flags_in,
  output logic [7:0] res,
  output logic [7:0] flags_out,
  output logic [2:0] len,
  output logic [2:0] cyc
);

  always_comb begin
    res = cltf_pkg::cltf_is_xor(op) ? (dst ^ src) : (dst & src);
    flags_out = flags_in;
    flags_out[`CLTF_FLG_Z] = (res == 8'h00);
    flags_out[`CLTF_FLG_S] = res[7];
    flags_out[`CLTF_FLG_V] = 1'b0;
    len = 3'h0;
    cyc = 3'h0;
    if (cltf_pkg::cltf_is_ext(op)) begin
      len = `CLTF_LEN_EXT;
      cyc = `CLTF_CYC_EXT;
    end else if (cltf_pkg::cltf_is_tm(op) || cltf_pkg::cltf_is_xor(op)) begin
      len = (op[3:0] <= `CLTF_OP_WRK_LAST) ? `CLTF_LEN_WRK : `CLTF_LEN_REG;
      cyc = op[0] ? `CLTF_CYC_IND : `CLTF_CYC_DIR;
    end else if (op == `CLTF_OP_TRAP) begin
      len = `CLTF_LEN_TRAP;
      cyc = `CLTF_CYC_TRAP;
    end
  end

endmodule

//--- src/cltf_core.sv
/*
  Logic-test, trap and flags unit of the 8-bit CPU core: bit test, xor,
  trap and interrupt stacking, interrupt return, flags and stack pointer,
  Avalon-MM register slave. Assumes a memory with one cycle read latency
  and a fetch unit presenting operands already read.
*/
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "cltf_consts.svh"
module cltf_core (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cltf_pkg::cltf_ins_s ins,
  output logic ins_ready,
  output logic [2:0] ins_len,
  input wire logic evt_irq,
  input wire logic evt_illegal,
  input wire logic evt_interrupt_return,
  input wire logic [7:0] evt_vector,
  output logic evt_ack,
  input wire logic alu_flag_we,
  input wire logic [5:0] alu_status,
  input wire logic user_we,
  input wire logic [1:0] user_val,
  input wire logic [3:0] cc_sel,
  output logic cc_true,
  output logic [7:0] flags_out,
  input wire logic [15:0] pc_cur,
  output logic pc_load,
  output logic [15:0] pc_new,
  output cltf_pkg::cltf_mem_s mem,
  input wire logic [7:0] mem_rdata,
  output logic res_we,
  output logic [7:0] res_val,
  output logic [3:0] dec_wreg,
  output logic [7:0] dec_reg,
  output logic [15:0] dec_disp
);

  localparam cltf_pkg::cltf_st_s ST_RST = '{
    state: cltf_pkg::CLTF_IDLE,
    sts: `CLTF_STS_RST,
    sp: `CLTF_SP_RST,
    default: '0
  };

  cltf_pkg::cltf_st_s st_ff;
  cltf_pkg::cltf_st_s nxt_st;
  logic [1:0] usr_ff;
  logic [1:0] nxt_usr;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic [2:0] alu_cyc;
  logic idle;
  logic evt_pend;
  logic evt_trap;
  logic acc;
  logic bus_req;
  logic bus_done;
  logic flg_wr;
  logic commit;

  cltf_alu u_alu (
    .op(ins.opcode),
    .dst(ins.dst),
    .src(ins.src),
    .flags_in(flags_out),
    .res(alu_res),
    .flags_out(alu_flags),
    .len(ins_len),
    .cyc(alu_cyc)
  );

  assign flags_out = {st_ff.sts, usr_ff};

  assign idle = (st_ff.state == cltf_pkg::CLTF_IDLE);
  assign evt_trap = evt_irq | evt_illegal;
  assign evt_pend = evt_trap | evt_interrupt_return;
  assign evt_ack = idle & clk_en & evt_pend;
  assign ins_ready = idle & ~st_ff.halt & ~evt_pend;
  assign acc = ins.valid & ins_ready & clk_en;
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~st_ff.ack;
  assign bus_done = bus_req & st_ff.ack;
  assign flg_wr = bus_done & avs_write & (avs_address == `CLTF_REG_FLAGS);
  assign commit = (st_ff.state == cltf_pkg::CLTF_EXEC) && (st_ff.cnt == 3'h1);

  always_comb begin
    logic go_trap;
    logic [7:0] go_vec;
    go_trap = 1'b0;
    go_vec = evt_vector;
    nxt_st = st_ff;
    nxt_st.mem = '0;
    nxt_st.pc_load = 1'b0;
    nxt_st.res_we = 1'b0;
    nxt_st.ack = bus_req & ~st_ff.ack;
    if (bus_req & ~st_ff.ack) begin
      case (avs_address)
        `CLTF_REG_FLAGS: nxt_st.rdata = {24'h000000, flags_out};
        `CLTF_REG_SP: nxt_st.rdata = {16'h0000, st_ff.sp};
        `CLTF_REG_STATUS: nxt_st.rdata = {17'h00000, st_ff.cnt, st_ff.state};
        `CLTF_REG_CTRL: nxt_st.rdata = {31'h00000000, st_ff.halt};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
    nxt_st.dwreg = ins.opd[3:0];
    nxt_st.dreg = ins.opd;
    nxt_st.ddisp = {{8{ins.opd[7]}}, ins.opd};
    if (bus_done & avs_write) begin
      case (avs_address)
        `CLTF_REG_FLAGS: begin
          if (idle) begin
            nxt_st.sts = avs_writedata[7:2];
          end
        end
        `CLTF_REG_SP: begin
          if (idle) begin
            nxt_st.sp = avs_writedata[15:0];
          end
        end
        `CLTF_REG_CTRL: nxt_st.halt = avs_writedata[0];
        default: nxt_st.halt = st_ff.halt;
      endcase
    end
    unique case (st_ff.state)
      cltf_pkg::CLTF_IDLE: begin
        if (evt_trap) begin
          go_trap = 1'b1;
        end else if (evt_interrupt_return) begin
          nxt_st.mem.rd = 1'b1;
          nxt_st.mem.addr = st_ff.sp;
          nxt_st.state = cltf_pkg::CLTF_POPF;
        end else if (acc && ins.opcode == `CLTF_OP_TRAP) begin
          go_trap = 1'b1;
          go_vec = ins.src;
        end else if (acc && alu_cyc != 3'h0) begin
          nxt_st.op = ins.opcode;
          nxt_st.res = alu_res;
          nxt_st.res_sts = alu_flags[7:2];
          nxt_st.cnt = alu_cyc - 3'h1;
          nxt_st.state = cltf_pkg::CLTF_EXEC;
        end else if (alu_flag_we) begin
          nxt_st.sts = alu_status;
        end
        if (go_trap) begin
          nxt_st.vec = go_vec;
          nxt_st.pc = pc_cur;
          nxt_st.sp = st_ff.sp - 16'h0002;
          nxt_st.mem.we = 1'b1;
          nxt_st.mem.addr = st_ff.sp - 16'h0002;
          nxt_st.mem.wdata = pc_cur[15:8];
          nxt_st.state = cltf_pkg::CLTF_PCH;
        end
      end
      cltf_pkg::CLTF_EXEC: begin
        nxt_st.cnt = st_ff.cnt - 3'h1;
        if (commit) begin
          nxt_st.sts = st_ff.res_sts;
          nxt_st.res_we = cltf_pkg::cltf_is_xor(st_ff.op);
          nxt_st.state = cltf_pkg::CLTF_IDLE;
        end
      end
      cltf_pkg::CLTF_PCH: begin
        nxt_st.mem.we = 1'b1;
        nxt_st.mem.addr = st_ff.sp + 16'h0001;
        nxt_st.mem.wdata = st_ff.pc[7:0];
        nxt_st.state = cltf_pkg::CLTF_PCL;
      end
      cltf_pkg::CLTF_PCL: begin
        nxt_st.sp = st_ff.sp - 16'h0001;
        nxt_st.mem.we = 1'b1;
        nxt_st.mem.addr = st_ff.sp - 16'h0001;
        nxt_st.mem.wdata = flags_out;
        nxt_st.state = cltf_pkg::CLTF_FLG;
      end
      cltf_pkg::CLTF_FLG: begin
        nxt_st.mem.rd = 1'b1;
        nxt_st.mem.addr = {8'h00, st_ff.vec};
        nxt_st.state = cltf_pkg::CLTF_RDH;
      end
      cltf_pkg::CLTF_RDH: begin
        nxt_st.mem.rd = 1'b1;
        nxt_st.mem.addr = {8'h00, st_ff.vec} + 16'h0001;
        nxt_st.state = cltf_pkg::CLTF_RDL;
      end
      cltf_pkg::CLTF_RDL: begin
        nxt_st.pc[15:8] = mem_rdata;
        nxt_st.state = cltf_pkg::CLTF_CAP;
      end
      cltf_pkg::CLTF_CAP: begin
        nxt_st.pc_new = {st_ff.pc[15:8], mem_rdata};
        nxt_st.pc_load = 1'b1;
        nxt_st.state = cltf_pkg::CLTF_IDLE;
      end
      cltf_pkg::CLTF_POPF: begin
        nxt_st.mem.rd = 1'b1;
        nxt_st.mem.addr = st_ff.sp + 16'h0001;
        nxt_st.state = cltf_pkg::CLTF_POPH;
      end
      cltf_pkg::CLTF_POPH: begin
        nxt_st.sts = mem_rdata[7:2];
        nxt_st.mem.rd = 1'b1;
        nxt_st.mem.addr = st_ff.sp + 16'h0002;
        nxt_st.state = cltf_pkg::CLTF_POPL;
      end
      cltf_pkg::CLTF_POPL: begin
        nxt_st.pc[15:8] = mem_rdata;
        nxt_st.state = cltf_pkg::CLTF_POPC;
      end
      cltf_pkg::CLTF_POPC: begin
        nxt_st.pc_new = {st_ff.pc[15:8], mem_rdata};
        nxt_st.pc_load = 1'b1;
        nxt_st.sp = st_ff.sp + 16'h0003;
        nxt_st.state = cltf_pkg::CLTF_IDLE;
      end
      default: nxt_st.state = cltf_pkg::CLTF_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= ST_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    nxt_usr = usr_ff;
    if (flg_wr && idle) begin
      nxt_usr = avs_writedata[1:0];
    end
    if (user_we) begin
      nxt_usr = user_val;
    end
    if (st_ff.state == cltf_pkg::CLTF_POPH) begin
      nxt_usr = mem_rdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      usr_ff <= nxt_usr;
    end
  end

  assign cc_true = cltf_pkg::cltf_cond(flags_out, cc_sel);

  assign avs_readdata = st_ff.rdata;
  assign pc_load = st_ff.pc_load;
  assign pc_new = st_ff.pc_new;
  assign mem = st_ff.mem;
  assign res_we = st_ff.res_we;
  assign res_val = st_ff.res;
  assign dec_wreg = st_ff.dwreg;
  assign dec_reg = st_ff.dreg;
  assign dec_disp = st_ff.ddisp;

  property p_alu_upd;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      idle && !evt_pend && !acc && alu_flag_we |=> flags_out[7:2] == $past(alu_status);
  endproperty
  a_alu_upd: assert property (p_alu_upd) else $error("status not taken from alu");

  property p_cond;
    @(posedge core_clk) disable iff (!rstn)
      cc_sel[2:0] == `CLTF_CC_V |-> cc_true == (flags_out[`CLTF_FLG_V] ^ cc_sel[3]);
  endproperty
  a_cond: assert property (p_cond) else $error("overflow condition wrong");

  property p_no_hd;
    @(posedge core_clk) disable iff (!rstn)
      cc_sel[2:0] > `CLTF_CC_ALW |-> cc_true == cc_sel[3];
  endproperty
  a_no_hd: assert property (p_no_hd) else $error("unused condition not constant");

  property p_usr_keep;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      !user_we && !flg_wr && st_ff.state != cltf_pkg::CLTF_POPH |=> $stable(usr_ff);
  endproperty
  a_usr_keep: assert property (p_usr_keep) else $error("user flags changed");

  property p_flag_push;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      evt_ack && evt_trap && !user_we |-> ##3 st_ff.mem.we && st_ff.mem.wdata == $past(flags_out, 3);
  endproperty
  a_flag_push: assert property (p_flag_push) else $error("flags not pushed");

  property p_interrupt_return;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      st_ff.state == cltf_pkg::CLTF_POPH |=> flags_out[7:2] == $past(mem_rdata[7:2]);
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("flags not restored");

  property p_tm;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      commit && cltf_pkg::cltf_is_tm(st_ff.op) |=> !res_we && !flags_out[`CLTF_FLG_V]
        && flags_out[`CLTF_FLG_Z] == ($past(st_ff.res) == 8'h00);
  endproperty
  a_tm: assert property (p_tm) else $error("bit test result or flags wrong");

  property p_ext_cyc;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      acc && cltf_pkg::cltf_is_ext(ins.opcode) |=> st_ff.state == cltf_pkg::CLTF_EXEC
        ##1 st_ff.state == cltf_pkg::CLTF_EXEC ##1 idle;
  endproperty
  a_ext_cyc: assert property (p_ext_cyc) else $error("extended form not three cycles");

  property p_trap;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      acc && ins.opcode == `CLTF_OP_TRAP |=> st_ff.mem.we && st_ff.mem.addr == $past(st_ff.sp) - 16'h0002
        ##1 st_ff.mem.we ##1 st_ff.mem.we && st_ff.mem.addr == $past(st_ff.sp, 3) - 16'h0003
        ##1 st_ff.mem.rd ##3 pc_load;
  endproperty
  a_trap: assert property (p_trap) else $error("trap stacking sequence wrong");

  property p_xor;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      commit && cltf_pkg::cltf_is_xor(st_ff.op) |=> res_we && res_val == $past(st_ff.res)
        && !flags_out[`CLTF_FLG_V] && flags_out[`CLTF_FLG_C] == $past(flags_out[`CLTF_FLG_C]);
  endproperty
  a_xor: assert property (p_xor) else $error("xor store or flags wrong");

  property p_extended_exclusive_or;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      acc && ins.opcode[7:1] == (`CLTF_OP_EXTENDED_EXCLUSIVE_OR_FIRST >> 1) |-> ##3 res_we;
  endproperty
  a_extended_exclusive_or: assert property (p_extended_exclusive_or) else $error("extended xor not stored");

  property p_disp;
    @(posedge core_clk) disable iff (!rstn || !clk_en)
      1'b1 |=> dec_disp == {{8{$past(ins.opd[7])}}, $past(ins.opd)} && dec_wreg == $past(ins.opd[3:0]);
  endproperty
  a_disp: assert property (p_disp) else $error("operand decode wrong");

endmodule

//--- bench/cltf_mem_model.sv
/*
  Memory partner of the flags unit: byte store with one cycle read latency.
  Assumes stack and vector addresses below 0x100, one request per cycle.
*/
`timescale 1ns/100ps
module cltf_mem_model (
  input wire logic core_clk,
  input wire cltf_pkg::cltf_mem_s mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:255];
  logic [7:0] rd_ff;
  logic vld_ff;
  initial vld_ff = 1'b0;
  initial rd_ff = 8'h00;
  always @(posedge core_clk) begin
    vld_ff <= mem.rd;
    if (mem.rd)
      rd_ff <= ram[mem.addr[7:0]];
    if (mem.we)
      ram[mem.addr[7:0]] <= mem.wdata;
  end
  // outside the answer cycle the line shows the inverted last byte
  assign mem_rdata = vld_ff ? rd_ff : ~rd_ff;
endmodule

//--- bench/tb.sv
/*
  Testbench of the flags unit: Avalon register tasks, instruction and event
  sequences with expected values. Assumes the memory partner model.
*/
`timescale 1ns/100ps
module tb;
  logic core_clk, rstn, clk_en, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, cc_sel, dec_wreg;
  logic [31:0] avs_writedata, avs_readdata, q;
  cltf_pkg::cltf_ins_s ins;
  cltf_pkg::cltf_mem_s mem;
  logic ins_ready, evt_irq, evt_illegal, evt_interrupt_return, evt_ack;
  logic alu_flag_we, user_we, cc_true, pc_load, res_we;
  logic [2:0] ins_len, cyc, len;
  logic [7:0] evt_vector, flags_out, mem_rdata, res_val, dec_reg, op, d, s, r;
  logic [5:0] alu_status;
  logic [1:0] user_val;
  logic [15:0] pc_cur, pc_new, dec_disp;
  int error_cnt, tests_run, n;

  cltf_core u_cltf_core (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ins(ins), .ins_ready(ins_ready), .ins_len(ins_len),
    .evt_irq(evt_irq), .evt_illegal(evt_illegal), .evt_interrupt_return(evt_interrupt_return),
    .evt_vector(evt_vector), .evt_ack(evt_ack), .alu_flag_we(alu_flag_we),
    .alu_status(alu_status), .user_we(user_we), .user_val(user_val), .cc_sel(cc_sel),
    .cc_true(cc_true), .flags_out(flags_out), .pc_cur(pc_cur), .pc_load(pc_load),
    .pc_new(pc_new), .mem(mem), .mem_rdata(mem_rdata), .res_we(res_we), .res_val(res_val),
    .dec_wreg(dec_wreg), .dec_reg(dec_reg), .dec_disp(dec_disp));
  cltf_mem_model u_cltf_mem_model (.core_clk(core_clk), .mem(mem), .mem_rdata(mem_rdata));

  always #20 core_clk = ~core_clk;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo;
    error_cnt++;
    $display("ERROR t=%0t wait bound used up got=%h exp=%h", $time, 1'b0, 1'b1);
    finish_test();
  endtask

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] rq);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) tmo();
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic av_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    av(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask

  task automatic set_sts(input logic [5:0] v);
    @(posedge core_clk);
    alu_status <= v;
    alu_flag_we <= 1'b1;
    @(posedge core_clk);
    alu_flag_we <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic issue(input logic [7:0] o, dd, ss, input logic [2:0] elen);
    int i;
    @(posedge core_clk);
    ins <= {1'b1, o, dd, ss, 8'h00};
    for (i = 0; i < 50; i++) begin
      @(negedge core_clk);
      if (ins_ready === 1'b1) break;
      @(posedge core_clk);
    end
    if (i == 50) tmo();
    chk(ins_len, elen);
    @(posedge core_clk);
    ins.valid <= 1'b0;
  endtask

  // counts falling edges until the chosen output shows up
  task automatic wait_hi(input int w, output int cnt);
    logic hit;
    for (cnt = 1; cnt < 60; cnt++) begin
      @(negedge core_clk);
      case (w)
        0: hit = pc_load;
        1: hit = evt_ack;
        default: hit = (flags_out[6:4] !== 3'b111);
      endcase
      if (hit === 1'b1) break;
      @(posedge core_clk);
    end
    if (cnt == 60) tmo();
  endtask

  task automatic evt(input int w);
    int m;
    @(posedge core_clk);
    evt_irq <= (w == 0);
    evt_illegal <= (w == 1);
    evt_interrupt_return <= (w == 2);
    wait_hi(1, m);
    @(posedge core_clk);
    evt_irq <= 1'b0;
    evt_illegal <= 1'b0;
    evt_interrupt_return <= 1'b0;
    wait_hi(0, m);
  endtask

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    ins = '0;
    {evt_irq, evt_illegal, evt_interrupt_return, alu_flag_we} = '0;
    // user flags get a known value by an explicit write during reset
    user_we = 1'b1;
    evt_vector = 8'h20;
    alu_status = 6'h00;
    user_val = 2'b11;
    cc_sel = 4'h0;
    pc_cur = 16'h1234;
    u_cltf_mem_model.ram[8'h20] = 8'hAB;
    u_cltf_mem_model.ram[8'h21] = 8'hCD;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    user_we <= 1'b0;
    @(negedge core_clk);
    // status bits clear after reset, user bits as written
    chk(flags_out, 8'h03);
    av_chk(4'h8, 32'h1);
    av_chk(4'h2, 32'h0);
    av_chk(4'h4, 32'h0);
    av(1'b1, 4'h8, 32'hFF, q);
    av_chk(4'h8, 32'h1);
    av(1'b1, 4'hC, 32'h1, q);
    chk(ins_ready, 1'b0);
    av_chk(4'hC, 32'h1);
    av(1'b1, 4'hC, 32'h0, q);
    av(1'b1, 4'h0, 32'hC5, q);
    av_chk(4'h0, 32'hC5);
    $display("test registers done");
    set_sts(6'h2A);
    chk(flags_out, 8'hA9);
    // jump conditions on carry, zero, sign, overflow and always; codes above always are constant
    for (int c = 0; c < 16; c++) begin
      @(posedge core_clk);
      cc_sel <= c[3:0];
      @(negedge core_clk);
      chk(cc_true, ((c % 8 == 0) || (c % 8 == 2) || (c % 8 == 4)) ^ c[3]);
    end
    $display("test conditions done");
    // every form, flags, store and timing
    for (int k = 0; k < 18; k++) begin
      op = (k < 8) ? 8'h72 + k[7:0] : (k < 16) ? 8'hAA + k[7:0] : (k == 16) ? 8'h72 : 8'hB2;
      d = (k == 16) ? 8'h80 : 8'h3C;
      s = (k == 16) ? 8'h80 : (k == 17) ? 8'h3C : 8'h1E;
      r = op[7] ? d ^ s : d & s;
      cyc = (op[3:0] >= 4'h8) ? 3'h3 : op[0] ? 3'h4 : 3'h3;
      len = (op[3:0] < 4'h4) ? 3'h2 : (op[3:0] < 4'h8) ? 3'h3 : 3'h4;
      set_sts(6'h3F);
      issue(op, d, s, len);
      wait_hi(2, n);
      chk(n, cyc);
      chk(flags_out, {1'b1, r == 8'h00, r[7], 1'b0, 2'b11, 2'b01});
      chk(res_we, op[7]);
      if (op[7]) chk(res_val, r);
    end
    $display("test logic ops done");
    // trap stacking order and vector load
    av(1'b1, 4'h4, 32'h40, q);
    set_sts(6'h2A);
    issue(8'hF2, 8'h00, 8'h20, 3'h2);
    wait_hi(0, n);
    chk(n, 7);
    chk(pc_new, 16'hABCD);
    chk(u_cltf_mem_model.ram[8'h3E], 8'h12);
    chk(u_cltf_mem_model.ram[8'h3F], 8'h34);
    chk(u_cltf_mem_model.ram[8'h3D], 8'hA9);
    av_chk(4'h4, 32'h3D);
    // interrupt and illegal trap push flags
    set_sts(6'h15);
    evt(0);
    chk(u_cltf_mem_model.ram[8'h3A], 8'h55);
    set_sts(6'h0B);
    evt(1);
    chk(u_cltf_mem_model.ram[8'h37], 8'h2D);
    av_chk(4'h4, 32'h37);
    u_cltf_mem_model.ram[8'h37] = 8'h5A;
    u_cltf_mem_model.ram[8'h38] = 8'h45;
    u_cltf_mem_model.ram[8'h39] = 8'h67;
    evt(2);
    chk(pc_new, 16'h4567);
    chk(flags_out, 8'h5A);
    av_chk(4'h4, 32'h3A);
    $display("test traps done");
    // operand field widths and signed index
    for (int k = 0; k < 2; k++) begin
      op = k ? 8'h7A : 8'hF5;
      @(posedge core_clk);
      ins.opd <= op;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk(dec_wreg, op[3:0]);
      chk(dec_reg, op);
      chk(dec_disp, {{8{op[7]}}, op});
    end
    @(posedge core_clk);
    user_val <= 2'b01;
    user_we <= 1'b1;
    @(posedge core_clk);
    user_we <= 1'b0;
    @(negedge core_clk);
    chk(flags_out, 8'h59);
    // a low clock enable freezes the flags
    @(posedge core_clk);
    clk_en <= 1'b0;
    alu_status <= 6'h3F;
    alu_flag_we <= 1'b1;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    alu_flag_we <= 1'b0;
    @(negedge core_clk);
    chk(flags_out, 8'h59);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk(flags_out, 8'h01);
    $display("test decode and reset done");
    finish_test();
  end
endmodule
